// ===== phy_status_diag_registers.sv
// Contract
// - Page receive flag sets, clears on read
// - Parallel detect fault flag sets, clears on read
// - Partner acknowledge flag sets, clears on read
// - Link down flag sets, clears on read
// - Remote fault flag sets, clears on read
// - Link up flag sets, clears on read
// - Diagnostic start bit holds until test ends
// - Results valid once start bit clears
// - Two-bit diagnostic outcome code, reset 00
// - Short cable indicator, reset 0
// - Pause capability status bit
// - Polarity reversed status bit
// - Energy detect status bit
// - Enabled flags alone drive interrupt
// - Interrupt level bit selects pin polarity
`timescale 1ns/100ps
`default_nettype none
module phy_status_diag_registers #(
   parameter logic [4:0] PHY_ADDR = 5'h01
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Management pins
   input wire logic mdc,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe,
   // Event pulses from the line logic
   input wire logic ev_jabber,
   input wire logic ev_rx_err,
   input wire logic ev_page_rx,
   input wire logic ev_pd_fault,
   input wire logic ev_partner_ack,
   input wire logic ev_remote_fault,
   // Line status levels
   input wire logic link_up,
   input wire logic pause_cap,
   input wire logic polarity_rev,
   input wire logic mdix_state,
   input wire logic energy_det,
   // Cable diagnostic engine
   output logic diag_run,
   input wire logic diag_done,
   input wire logic [1:0] diag_result,
   input wire logic diag_short,
   input wire logic [8:0] diag_dist,
   // Interrupt pin
   output logic int_pin
);

   logic rd_stb, wr_stb;
   logic [4:0] reg_addr;
   logic [15:0] wr_data;
   logic [15:0] rd_data;
   logic [7:0] flags_r;
   logic [7:0] int_en_r;
   logic [7:0] ev_vec;
   logic [7:0] rd_clr;
   logic [4:0] stat_r;
   logic link_prev_r;
   phy_diag_pkg::diag_result_t res_r;
   logic short_r;
   logic [2:0] diag_rsv_r;
   logic [8:0] dist_r;
   logic [15:0] ctl2_r;
   logic wr_int, wr_diag, wr_ctl2;

   mgmt_serial_slave #(
      .PHY_ADDR(PHY_ADDR)
   ) u_serial (
      .clk(clk),
      .rstn(rstn),
      .mdc(mdc),
      .mdio_i(mdio_i),
      .mdio_o(mdio_o),
      .mdio_oe(mdio_oe),
      .rd_stb(rd_stb),
      .wr_stb(wr_stb),
      .reg_addr(reg_addr),
      .wr_data(wr_data),
      .rd_data(rd_data)
   );

   assign wr_int = wr_stb && reg_addr == phy_diag_pkg::REG_INT_CS;
   assign wr_diag = wr_stb && reg_addr == phy_diag_pkg::REG_CABLE_DIAG;
   assign wr_ctl2 = wr_stb && reg_addr == phy_diag_pkg::REG_PHY_CTL2;

   // Status sampling; link edges become events
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stat_r <= phy_diag_pkg::STAT_RESET;
         link_prev_r <= 1'b0;
      end else begin
         stat_r <= {pause_cap, link_up, polarity_rev, mdix_state, energy_det};
         link_prev_r <= stat_r[3];
      end
   end

   always_comb begin
      ev_vec = 8'h00;
      ev_vec[phy_diag_pkg::EV_JABBER] = ev_jabber;
      ev_vec[phy_diag_pkg::EV_RX_ERR] = ev_rx_err;
      ev_vec[phy_diag_pkg::EV_PAGE_RX] = ev_page_rx;
      ev_vec[phy_diag_pkg::EV_PD_FAULT] = ev_pd_fault;
      ev_vec[phy_diag_pkg::EV_PARTNER_ACK] = ev_partner_ack;
      ev_vec[phy_diag_pkg::EV_LINK_DOWN] = link_prev_r & ~stat_r[3];
      ev_vec[phy_diag_pkg::EV_REM_FAULT] = ev_remote_fault;
      ev_vec[phy_diag_pkg::EV_LINK_UP] = ~link_prev_r & stat_r[3];
   end

   // Sticky flags: a read clears, a same-cycle event wins
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_flag
         assign rd_clr[gi] = rd_stb && reg_addr == phy_diag_pkg::REG_INT_CS;
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               flags_r[gi] <= phy_diag_pkg::FLAGS_RESET[gi];
            end else begin
               flags_r[gi] <= ev_vec[gi] | (flags_r[gi] & ~rd_clr[gi]);
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         int_en_r <= phy_diag_pkg::INT_EN_RESET;
      end else if (wr_int) begin
         int_en_r <= wr_data[15:phy_diag_pkg::INT_EN_LSB];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctl2_r <= phy_diag_pkg::CTL2_RESET;
      end else if (wr_ctl2) begin
         ctl2_r <= wr_data;
      end
   end

   // Interrupt pin, polarity from the level bit
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         int_pin <= 1'b1;
      end else begin
         int_pin <= (|(flags_r & int_en_r)) ~^ ctl2_r[phy_diag_pkg::CTL2_INT_LEVEL];
      end
   end

   // Cable diagnostic: start on write, clear and capture on done
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         diag_run <= 1'b0;
         res_r <= phy_diag_pkg::DIAG_NORMAL;
         short_r <= 1'b0;
         dist_r <= phy_diag_pkg::DIAG_DIST_RESET;
      end else if (diag_run) begin
         if (diag_done) begin
            diag_run <= 1'b0;
            res_r <= phy_diag_pkg::diag_result_t'(diag_result);
            short_r <= diag_short;
            dist_r <= diag_dist;
         end
      end else if (wr_diag && wr_data[phy_diag_pkg::DIAG_START_BIT]) begin
         diag_run <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         diag_rsv_r <= phy_diag_pkg::DIAG_RSV_RESET;
      end else if (wr_diag) begin
         diag_rsv_r <= wr_data[phy_diag_pkg::DIAG_RSV_LSB +: 3];
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      rd_data = 16'h0000;
      unique case (reg_addr)
         phy_diag_pkg::REG_INT_CS: rd_data = {int_en_r, flags_r};
         phy_diag_pkg::REG_CABLE_DIAG: begin
            rd_data[phy_diag_pkg::DIAG_START_BIT] = diag_run;
            rd_data[phy_diag_pkg::DIAG_RES_LSB +: 2] = res_r;
            rd_data[phy_diag_pkg::DIAG_SHORT_BIT] = short_r;
            rd_data[phy_diag_pkg::DIAG_RSV_LSB +: 3] = diag_rsv_r;
            rd_data[phy_diag_pkg::DIAG_DIST_LSB +: 9] = dist_r;
         end
         phy_diag_pkg::REG_PHY_STAT: begin
            rd_data[phy_diag_pkg::STAT_PAUSE] = stat_r[4];
            rd_data[phy_diag_pkg::STAT_LINK] = stat_r[3];
            rd_data[phy_diag_pkg::STAT_POLARITY] = stat_r[2];
            rd_data[phy_diag_pkg::STAT_MDIX] = stat_r[1];
            rd_data[phy_diag_pkg::STAT_ENERGY] = stat_r[0];
         end
         phy_diag_pkg::REG_PHY_CTL2: rd_data = ctl2_r;
         default: rd_data = 16'h0000;
      endcase
   end

   sequence s_diag_started;
      !diag_run && wr_diag && wr_data[phy_diag_pkg::DIAG_START_BIT];
   endsequence

   sequence s_diag_finished;
      diag_run && diag_done;
   endsequence

   a_page_flag_set: assert property (@(posedge clk) disable iff (!rstn)
      ev_page_rx |=> flags_r[5]) else $error("page flag not set");
   a_pdf_flag_set: assert property (@(posedge clk) disable iff (!rstn)
      ev_pd_fault |=> flags_r[phy_diag_pkg::EV_PD_FAULT] &&
      (reg_addr != phy_diag_pkg::REG_INT_CS || rd_data[phy_diag_pkg::EV_PD_FAULT]))
      else $error("pd fault flag lost");
   a_ack_flag_set: assert property (@(posedge clk) disable iff (!rstn)
      ev_partner_ack |=> flags_r[3]) else $error("ack flag not set");
   a_flag_read_clear: assert property (@(posedge clk) disable iff (!rstn)
      rd_stb && reg_addr == phy_diag_pkg::REG_INT_CS && !ev_remote_fault |=> !flags_r[phy_diag_pkg::EV_REM_FAULT])
      else $error("flag not cleared by read");
   a_link_down_flag: assert property (@(posedge clk) disable iff (!rstn)
      $fell(stat_r[3]) |=> flags_r[2]) else $error("link down flag missing");
   a_link_up_flag: assert property (@(posedge clk) disable iff (!rstn)
      $rose(stat_r[3]) |=> flags_r[0]) else $error("link up flag missing");
   a_diag_start_hold: assert property (@(posedge clk) disable iff (!rstn)
      s_diag_started ##1 (!diag_done)[*2] |=> diag_run) else $error("diag start bit dropped early");
   a_diag_result_cap: assert property (@(posedge clk) disable iff (!rstn)
      s_diag_finished |=> !diag_run && res_r == $past(diag_result) && short_r == $past(diag_short)
      && dist_r == $past(diag_dist)) else $error("diag results not valid at clear");
   a_status_follow: assert property (@(posedge clk) disable iff (!rstn)
      ##2 (reg_addr != phy_diag_pkg::REG_PHY_STAT || rd_data[phy_diag_pkg::STAT_LINK] == $past(link_up)))
      else $error("link status stale");
   a_int_pin_level: assert property (@(posedge clk) disable iff (!rstn)
      ##1 int_pin == ((|($past(flags_r) & $past(int_en_r))) ~^ $past(ctl2_r[phy_diag_pkg::CTL2_INT_LEVEL])))
      else $error("interrupt pin wrong");

endmodule : phy_status_diag_registers
`default_nettype wire

// ===== phy_diag_pkg.sv
package phy_diag_pkg;

   // Register addresses on the management interface
   localparam logic [4:0] REG_INT_CS = 5'h1B;
   localparam logic [4:0] REG_CABLE_DIAG = 5'h1D;
   localparam logic [4:0] REG_PHY_STAT = 5'h1E;
   localparam logic [4:0] REG_PHY_CTL2 = 5'h1F;

   // Interrupt control/status: flags in the low byte, enables in the high byte
   localparam int unsigned INT_EN_LSB = 8;
   localparam int unsigned EV_LINK_UP = 0;
   localparam int unsigned EV_REM_FAULT = 1;
   localparam int unsigned EV_LINK_DOWN = 2;
   localparam int unsigned EV_PARTNER_ACK = 3;
   localparam int unsigned EV_PD_FAULT = 4;
   localparam int unsigned EV_PAGE_RX = 5;
   localparam int unsigned EV_RX_ERR = 6;
   localparam int unsigned EV_JABBER = 7;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] INT_EN_RESET = 8'h00;

   // Cable diagnostic control/status
   localparam int unsigned DIAG_START_BIT = 15;
   localparam int unsigned DIAG_RES_LSB = 13;
   localparam int unsigned DIAG_SHORT_BIT = 12;
   localparam int unsigned DIAG_RSV_LSB = 9;
   localparam int unsigned DIAG_DIST_LSB = 0;
   localparam logic [2:0] DIAG_RSV_RESET = 3'h0;
   localparam logic [8:0] DIAG_DIST_RESET = 9'h000;

   typedef enum logic [1:0] {
      DIAG_NORMAL = 2'h0,
      DIAG_OPEN = 2'h1,
      DIAG_SHORT = 2'h2,
      DIAG_FAILED = 2'h3
   } diag_result_t;

   // PHY status bits
   localparam int unsigned STAT_PAUSE = 9;
   localparam int unsigned STAT_LINK = 8;
   localparam int unsigned STAT_POLARITY = 7;
   localparam int unsigned STAT_MDIX = 5;
   localparam int unsigned STAT_ENERGY = 4;
   localparam logic [4:0] STAT_RESET = 5'h00;

   // PHY control 2
   localparam int unsigned CTL2_INT_LEVEL = 9;
   localparam logic [15:0] CTL2_RESET = 16'h8100;

   // Management frame
   localparam logic [5:0] PREAMBLE_LEN = 6'h20;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [4:0] HDR_LAST = 5'h09;
   localparam logic [4:0] DATA_LAST = 5'h0F;

endpackage : phy_diag_pkg

// ===== mgmt_serial_slave.sv
`timescale 1ns/100ps
`default_nettype none
module mgmt_serial_slave #(
   parameter logic [4:0] PHY_ADDR = 5'h01
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Management pins
   input wire logic mdc,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe,
   // Register access
   output logic rd_stb,
   output logic wr_stb,
   output logic [4:0] reg_addr,
   output logic [15:0] wr_data,
   input wire logic [15:0] rd_data
);

   typedef enum logic [2:0] {ST_PRE, ST_START, ST_OP, ST_ADDR, ST_TA, ST_DATA} frame_state_t;

   frame_state_t state_r;
   logic mdc_s1_r, mdc_s2_r, mdc_s3_r;
   logic mdio_s1_r, mdio_s2_r;
   logic [5:0] ones_r;
   logic [4:0] cnt_r;
   logic [1:0] op_r;
   logic [9:0] hdr_r;
   logic [9:0] hdr_nxt;
   logic [15:0] shift_r;
   logic is_rd_r;
   logic rise;
   logic bit_in;

   // Both pins come from another party's timing
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mdc_s1_r <= 1'b0;
         mdc_s2_r <= 1'b0;
         mdc_s3_r <= 1'b0;
         mdio_s1_r <= 1'b1;
         mdio_s2_r <= 1'b1;
      end else begin
         mdc_s1_r <= mdc;
         mdc_s2_r <= mdc_s1_r;
         mdc_s3_r <= mdc_s2_r;
         mdio_s1_r <= mdio_i;
         mdio_s2_r <= mdio_s1_r;
      end
   end

   assign rise = mdc_s2_r & ~mdc_s3_r;
   assign bit_in = mdio_s2_r;
   assign hdr_nxt = {hdr_r[8:0], bit_in};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_PRE;
         ones_r <= 6'h00;
         cnt_r <= 5'h00;
         op_r <= 2'h0;
         hdr_r <= 10'h000;
         is_rd_r <= 1'b0;
         reg_addr <= 5'h00;
      end else if (rise) begin
         unique case (state_r)
            ST_PRE: begin
               if (bit_in) begin
                  if (ones_r != phy_diag_pkg::PREAMBLE_LEN) begin
                     ones_r <= ones_r + 6'h01;
                  end
               end else begin
                  if (ones_r == phy_diag_pkg::PREAMBLE_LEN) begin
                     state_r <= ST_START;
                  end
                  ones_r <= 6'h00;
               end
            end
            ST_START: begin
               state_r <= bit_in ? ST_OP : ST_PRE;
               cnt_r <= 5'h00;
            end
            ST_OP: begin
               op_r <= {op_r[0], bit_in};
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == 5'h01) begin
                  state_r <= ST_ADDR;
                  cnt_r <= 5'h00;
               end
            end
            ST_ADDR: begin
               hdr_r <= hdr_nxt;
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == phy_diag_pkg::HDR_LAST) begin
                  cnt_r <= 5'h00;
                  reg_addr <= hdr_nxt[4:0];
                  is_rd_r <= (op_r == phy_diag_pkg::OP_READ);
                  if (hdr_nxt[9:5] == PHY_ADDR &&
                      (op_r == phy_diag_pkg::OP_READ || op_r == phy_diag_pkg::OP_WRITE)) begin
                     state_r <= ST_TA;
                  end else begin
                     state_r <= ST_PRE;
                  end
               end
            end
            ST_TA: begin
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == 5'h01) begin
                  state_r <= ST_DATA;
                  cnt_r <= 5'h00;
               end
            end
            ST_DATA: begin
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == phy_diag_pkg::DATA_LAST) begin
                  state_r <= ST_PRE;
                  cnt_r <= 5'h00;
               end
            end
         endcase
      end
   end

   // Read strobe one cycle after the header; data captured on the next edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_stb <= 1'b0;
      end else begin
         rd_stb <= rise && state_r == ST_ADDR && cnt_r == phy_diag_pkg::HDR_LAST &&
                   hdr_nxt[9:5] == PHY_ADDR && op_r == phy_diag_pkg::OP_READ;
      end
   end

   // Shift register, pin drive and write strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         shift_r <= 16'h0000;
         mdio_o <= 1'b0;
         mdio_oe <= 1'b0;
         wr_stb <= 1'b0;
         wr_data <= 16'h0000;
      end else begin
         wr_stb <= 1'b0;
         if (rd_stb) begin
            shift_r <= rd_data;
         end else if (rise && is_rd_r) begin
            if (state_r == ST_TA && cnt_r == 5'h00) begin
               mdio_oe <= 1'b1;
               mdio_o <= 1'b0;
            end else if ((state_r == ST_TA) ||
                         (state_r == ST_DATA && cnt_r != phy_diag_pkg::DATA_LAST)) begin
               mdio_o <= shift_r[15];
               shift_r <= {shift_r[14:0], 1'b0};
            end else if (state_r == ST_DATA) begin
               mdio_oe <= 1'b0;
               mdio_o <= 1'b0;
            end
         end else if (rise && state_r == ST_DATA) begin
            shift_r <= {shift_r[14:0], bit_in};
            if (cnt_r == phy_diag_pkg::DATA_LAST) begin
               wr_stb <= 1'b1;
               wr_data <= {shift_r[14:0], bit_in};
            end
         end
      end
   end

endmodule : mgmt_serial_slave
`default_nettype wire

// ===== mgmt_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module mgmt_master_model #(
   parameter logic [4:0] PHY_ADDR = 5'h01
) (
   // Clock
   input wire logic clk,
   // Management pins
   input wire logic mdio_w,
   output logic mdc,
   output logic m_out,
   output logic m_oe
);
   logic s;
   initial begin
      mdc = 1'b0;
      m_out = 1'b1;
      m_oe = 1'b0;
   end
   // One mdc period, half period of 6 clk; pin sampled as mdc rises
   task automatic cyc(input logic b, output logic smp);
      @(negedge clk);
      mdc = 1'b0;
      m_out = b;
      repeat (6) @(negedge clk);
      smp = mdio_w;
      mdc = 1'b1;
      repeat (5) @(negedge clk);
   endtask : cyc
   task automatic header(input logic [1:0] op, input logic [4:0] addr);
      logic [13:0] h;
      h = {2'b01, op, PHY_ADDR, addr};
      m_oe = 1'b1;
      for (int i = 0; i < 32; i++) cyc(1'b1, s);
      for (int i = 13; i >= 0; i--) cyc(h[i], s);
   endtask : header
   // Clock stands still low between frames
   task automatic idle();
      @(negedge clk);
      mdc = 1'b0;
      m_oe = 1'b0;
      repeat (24) @(negedge clk);
   endtask : idle
   task automatic mgmt_write(input logic [4:0] addr, input logic [15:0] d);
      header(phy_diag_pkg::OP_WRITE, addr);
      cyc(1'b1, s);
      cyc(1'b0, s);
      for (int i = 15; i >= 0; i--) cyc(d[i], s);
      idle();
   endtask : mgmt_write
   task automatic mgmt_read(input logic [4:0] addr, output logic [15:0] d);
      header(phy_diag_pkg::OP_READ, addr);
      m_oe = 1'b0;
      cyc(1'b1, s);
      cyc(1'b1, s);
      for (int i = 15; i >= 0; i--) cyc(1'b1, d[i]);
      idle();
   endtask : mgmt_read
endmodule : mgmt_master_model
`default_nettype wire

// ===== phy_status_diag_registers_tb.sv
`timescale 1ns/100ps
`default_nettype none
module phy_status_diag_registers_tb;
   logic clk, rstn, mdc, mdio_o, mdio_oe, m_out, m_oe, mdio_w;
   logic [7:0] ev_v;
   logic link_up, pause_cap, polarity_rev, mdix_state, energy_det;
   logic diag_run, diag_done, diag_short, int_pin;
   logic [1:0] diag_result;
   logic [8:0] diag_dist;
   logic [15:0] rd, prev;
   int miscompares, check_count;
   int evs[6] = '{1, 3, 4, 5, 6, 7};
   logic [4:0] sts[3] = '{5'h15, 5'h0A, 5'h1F};
   logic [8:0] dists[4] = '{9'h000, 9'h0AA, 9'h155, 9'h1FF};

   // Pull-up on the shared data line
   assign mdio_w = mdio_oe ? mdio_o : (m_oe ? m_out : 1'b1);

   phy_status_diag_registers uut (.clk(clk), .rstn(rstn), .mdc(mdc), .mdio_i(mdio_w), .mdio_o(mdio_o),
      .mdio_oe(mdio_oe), .ev_jabber(ev_v[7]), .ev_rx_err(ev_v[6]), .ev_page_rx(ev_v[5]),
      .ev_pd_fault(ev_v[4]), .ev_partner_ack(ev_v[3]), .ev_remote_fault(ev_v[1]), .link_up(link_up),
      .pause_cap(pause_cap), .polarity_rev(polarity_rev), .mdix_state(mdix_state), .energy_det(energy_det),
      .diag_run(diag_run), .diag_done(diag_done), .diag_result(diag_result), .diag_short(diag_short),
      .diag_dist(diag_dist), .int_pin(int_pin));
   mgmt_master_model mm (.clk(clk), .mdio_w(mdio_w), .mdc(mdc), .m_out(m_out), .m_oe(m_oe));

   always #2.5 clk = ~clk;

   task automatic chk(input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         $display("Error at %0t: expected %h got %h", $time, e, g);
         miscompares++;
      end
   endtask : chk
   task automatic pin(input logic e, input logic g);
      chk({15'h0, e}, {15'h0, g});
   endtask : pin
   task automatic rchk(input logic [4:0] a, input logic [15:0] e);
      mm.mgmt_read(a, rd);
      chk(e, rd);
   endtask : rchk
   task automatic pulse(input int idx);
      @(negedge clk);
      ev_v[idx] = 1'b1;
      @(negedge clk);
      ev_v[idx] = 1'b0;
      repeat (4) @(negedge clk);
   endtask : pulse
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict

   initial begin
      repeat (90000) @(posedge clk);
      miscompares++;
      give_verdict();
   end

   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      ev_v = 8'h00;
      {pause_cap, link_up, polarity_rev, mdix_state, energy_det} = 5'h00;
      diag_done = 1'b0;
      diag_result = 2'h3;
      diag_short = 1'b1;
      diag_dist = 9'h1FF;
      prev = 16'h0000;
      repeat (20) @(posedge clk);
      @(negedge clk) rstn = 1'b1;
      repeat (4) @(negedge clk);
      pin(1'b1, int_pin);
      rchk(phy_diag_pkg::REG_INT_CS, 16'h0000);
      rchk(phy_diag_pkg::REG_CABLE_DIAG, 16'h0000);
      rchk(phy_diag_pkg::REG_PHY_STAT, 16'h0000);
      rchk(phy_diag_pkg::REG_PHY_CTL2, 16'h8100);
      rchk(5'h05, 16'h0000);
      // Each pulsed event flag (bits 1 and 3 to 7) sets on its event and clears once read
      foreach (evs[k]) begin
         pulse(evs[k]);
         rchk(phy_diag_pkg::REG_INT_CS, 16'h0001 << evs[k]);
         rchk(phy_diag_pkg::REG_INT_CS, 16'h0000);
      end
      foreach (sts[k]) begin
         @(negedge clk) {pause_cap, link_up, polarity_rev, mdix_state, energy_det} = sts[k];
         repeat (4) @(negedge clk);
         rchk(phy_diag_pkg::REG_PHY_STAT, {6'h0, sts[k][4:2], 1'b0, sts[k][1:0], 4'h0});
      end
      rchk(phy_diag_pkg::REG_INT_CS, 16'h0001);
      @(negedge clk) link_up = 1'b0;
      repeat (4) @(negedge clk);
      rchk(phy_diag_pkg::REG_INT_CS, 16'h0004);
      rchk(phy_diag_pkg::REG_INT_CS, 16'h0000);
      // Only the enabled page flag reaches the pin
      mm.mgmt_write(phy_diag_pkg::REG_INT_CS, 16'h20FF);
      rchk(phy_diag_pkg::REG_INT_CS, 16'h2000);
      pulse(phy_diag_pkg::EV_PD_FAULT);
      pin(1'b1, int_pin);
      rchk(phy_diag_pkg::REG_INT_CS, 16'h2010);
      pulse(phy_diag_pkg::EV_PAGE_RX);
      pin(1'b0, int_pin);
      mm.mgmt_write(phy_diag_pkg::REG_PHY_CTL2, 16'h8300);
      pin(1'b1, int_pin);
      rchk(phy_diag_pkg::REG_PHY_CTL2, 16'h8300);
      rchk(phy_diag_pkg::REG_INT_CS, 16'h2020);
      repeat (4) @(negedge clk);
      pin(1'b0, int_pin);
      // Completion before any start is ignored
      @(negedge clk) diag_done = 1'b1;
      @(negedge clk) diag_done = 1'b0;
      rchk(phy_diag_pkg::REG_CABLE_DIAG, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         mm.mgmt_write(phy_diag_pkg::REG_CABLE_DIAG, 16'hF1FF | (16'(i) << 9));
         pin(1'b1, diag_run);
         mm.mgmt_write(phy_diag_pkg::REG_CABLE_DIAG, 16'(i) << 9);
         pin(1'b1, diag_run);
         rchk(phy_diag_pkg::REG_CABLE_DIAG, 16'h8000 | (16'(i) << 9) | prev);
         @(negedge clk);
         diag_result = 2'(i);
         diag_short = i[0];
         diag_dist = dists[i];
         diag_done = 1'b1;
         @(negedge clk) diag_done = 1'b0;
         repeat (2) @(negedge clk);
         pin(1'b0, diag_run);
         rd = 16'h8000;
         for (int n = 0; n < 4 && rd[15] !== 1'b0; n++) mm.mgmt_read(phy_diag_pkg::REG_CABLE_DIAG, rd);
         prev = {1'b0, diag_result, diag_short, 3'h0, diag_dist};
         chk(prev | (16'(i) << 9), rd);
      end
      give_verdict();
   end
endmodule : phy_status_diag_registers_tb
`default_nettype wire
